/* File: common/rtc_pkg.sv */
package rtc_pkg;
	// Bus identity and speed
	localparam logic [6:0] SLAVE_ADDR = 7'h51;
	localparam int BUS_MAX_KBPS = 400;
	localparam int NUM_REGS = 16;
	// Register offsets
	localparam logic [3:0] A_CS1 = 4'h0;
	localparam logic [3:0] A_CS2 = 4'h1;
	localparam logic [3:0] A_SEC = 4'h2;
	localparam logic [3:0] A_YEAR = 4'h8;
	localparam logic [3:0] A_AMIN = 4'h9;
	localparam logic [3:0] A_AWDAY = 4'hc;
	localparam logic [3:0] A_SQW = 4'hd;
	localparam logic [3:0] A_TCTL = 4'he;
	localparam logic [3:0] A_TMR = 4'hf;
	// Field positions
	localparam int B_TIE = 0;
	localparam int B_AIE = 1;
	localparam int B_TF = 2;
	localparam int B_AF = 3;
	localparam int B_TITP = 4;
	localparam int B_STOP = 5;
	localparam int B_TOP = 7;
	// Reset values
	localparam logic [7:0] CS1_RST = 8'h08;
	localparam logic [7:0] SQW_RST = 8'h80;
	localparam logic [7:0] TCTL_RST = 8'h03;
	localparam logic [7:0] ALM_RST = 8'h80;
	// Timing
	localparam int CLK_HZ = 200_000_000;
	localparam int OSC_HZ = 32768;
	localparam int DIV_W = 15;
	localparam int OSC_STOP_US = 100;
	localparam int OSC_STOP_CYC = OSC_STOP_US * (CLK_HZ / 1_000_000);

	// Implemented bits of each register
	function automatic logic [7:0] reg_mask(input logic [3:0] a);
		unique case (a)
			4'h0: return 8'ha8;
			4'h1: return 8'h1f;
			4'h3: return 8'h7f;
			4'h4, 4'h5: return 8'h3f;
			4'h6: return 8'h07;
			4'h7: return 8'h9f;
			4'ha, 4'hb: return 8'hbf;
			4'hc: return 8'h87;
			4'hd, 4'he: return 8'h83;
			default: return 8'hff;
		endcase
	endfunction : reg_mask
endpackage : rtc_pkg

/* File: common/rtc_bus_if.sv */
`timescale 1ns/1ps
interface rtc_bus_if;
	logic addr_stb;
	logic wr_stb;
	logic rd_done;
	logic reading;
	logic bus_rst;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	modport slave(output addr_stb, wr_stb, rd_done, reading, wr_data, input rd_data, bus_rst);
	modport regs(input addr_stb, wr_stb, rd_done, reading, wr_data, output rd_data, bus_rst);
endinterface : rtc_bus_if

/* File: rtl/rtc_i2c_slave.sv */
`timescale 1ns/1ps
module rtc_i2c_slave (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Bus pins
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_oe,
	// Register side
	rtc_bus_if.slave bus
);
	typedef enum logic [6:0] {
		S_IDLE = 7'h01, S_ADDR = 7'h02, S_AACK = 7'h04, S_WR = 7'h08,
		S_WACK = 7'h10, S_RD = 7'h20, S_RACK = 7'h40
	} st_t;
	st_t st_q;
	logic [2:0] scl_q;
	logic [2:0] sda_q;
	logic [7:0] sh_q;
	logic [3:0] cnt_q;
	logic rw_q, first_q, nack_q, sda_low_q, addr_stb_q, wr_stb_q, rd_done_q;

	// Stage 0 only feeds stage 1; edges come from stages 1 and 2
	wire scl_rise = scl_q[1] & ~scl_q[2];
	wire scl_fall = ~scl_q[1] & scl_q[2];
	wire scl_hold = scl_q[1] & scl_q[2];
	wire start = scl_hold & ~sda_q[1] & sda_q[2];
	wire stop = scl_hold & sda_q[1] & ~sda_q[2];
	wire addr_hit = (sh_q[7:1] == rtc_pkg::SLAVE_ADDR);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end else begin
			scl_q <= {scl_q[1:0], scl};
			sda_q <= {sda_q[1:0], sda_in};
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q <= S_IDLE;
			sh_q <= 8'h00;
			cnt_q <= 4'h0;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			nack_q <= 1'b0;
			sda_low_q <= 1'b0;
			addr_stb_q <= 1'b0;
			wr_stb_q <= 1'b0;
			rd_done_q <= 1'b0;
		end else begin
			addr_stb_q <= 1'b0;
			wr_stb_q <= 1'b0;
			rd_done_q <= 1'b0;
			if (bus.bus_rst || stop) begin
				st_q <= S_IDLE;
				sda_low_q <= 1'b0;
			end else if (start) begin
				st_q <= S_ADDR;
				cnt_q <= 4'h0;
				sda_low_q <= 1'b0;
			end else if (scl_rise) begin
				if (st_q == S_ADDR || st_q == S_WR) begin
					sh_q <= {sh_q[6:0], sda_q[1]};
					cnt_q <= cnt_q + 4'h1;
				end
				if (st_q == S_RACK)
					nack_q <= sda_q[1];
			end else if (scl_fall) begin
				unique case (st_q)
					S_IDLE: ;
					S_ADDR: if (cnt_q == 4'h8) begin
						st_q <= addr_hit ? S_AACK : S_IDLE;
						sda_low_q <= addr_hit;
						rw_q <= sh_q[0];
						first_q <= 1'b1;
					end
					S_AACK: begin
						cnt_q <= 4'h0;
						st_q <= rw_q ? S_RD : S_WR;
						sh_q <= bus.rd_data;
						sda_low_q <= rw_q & ~bus.rd_data[7];
					end
					S_WR: if (cnt_q == 4'h8) begin
						st_q <= S_WACK;
						sda_low_q <= 1'b1;
						addr_stb_q <= first_q;
						wr_stb_q <= ~first_q;
						first_q <= 1'b0;
					end
					S_WACK: begin
						st_q <= S_WR;
						cnt_q <= 4'h0;
						sda_low_q <= 1'b0;
					end
					S_RD: if (cnt_q == 4'h7) begin
						st_q <= S_RACK;
						sda_low_q <= 1'b0;
						rd_done_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q + 4'h1;
						sh_q <= {sh_q[6:0], 1'b0};
						sda_low_q <= ~sh_q[6];
					end
					S_RACK: begin
						// Master NACK ends the read; wait for stop or restart
						st_q <= nack_q ? S_IDLE : S_RD;
						cnt_q <= 4'h0;
						sh_q <= bus.rd_data;
						sda_low_q <= ~nack_q & ~bus.rd_data[7];
					end
				endcase
			end
		end
	end

	assign sda_oe = sda_low_q;
	assign bus.addr_stb = addr_stb_q;
	assign bus.wr_stb = wr_stb_q;
	assign bus.rd_done = rd_done_q;
	assign bus.wr_data = sh_q;
	assign bus.reading = rw_q & (st_q == S_AACK || st_q == S_RD || st_q == S_RACK);

	a_addr_ack: assert property (@(posedge clk_sys) disable iff (rst)
		(st_q == S_ADDR && scl_fall && cnt_q == 4'h8 && addr_hit && !start && !stop
			&& !bus.bus_rst) |=> (sda_oe && st_q == S_AACK))
		else $error("address match not acknowledged");
	c_read_byte: cover property (@(posedge clk_sys) disable iff (rst) rd_done_q);
endmodule : rtc_i2c_slave

/* File: rtl/rtc_top.sv */
// How it works
// - Two-wire slave at A3h read, A2h write
// - Pointer advances after every data byte
// - Sixteen byte registers, some bits unimplemented
// - Offsets 0 and 1 hold control/status
// - Offsets 2 to 8 hold time counters
// - Offsets 9 to 0Ch hold alarm registers
// - Time and alarm registers are BCD
// - Time counters freeze while a read runs; divider and countdown keep counting
// - Timebase divided from 32.768 kHz oscillator
// - Alarm top bit set disables that match
// - Alarm match sets sticky alarm hit flag
// - Countdown control enables and picks source clock
// - Countdown reload sets sticky done flag
// - Pulse select picks pulsed or level interrupt
// - Countdown read returns present value
// - Square wave frequency selected at 0Dh
// - Square wave on after reset, disable floats
// - Stopped oscillator holds internal reset
// - Reset clears all but listed set bits
// - Supply low sets sticky flag in seconds
// - Interrupt pin open drain, active low
`timescale 1ns/1ps
module rtc_top #(
	parameter int OSC_STOP_CYC = rtc_pkg::OSC_STOP_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Crystal oscillator and supply monitor
	input wire logic osc_clk,
	input wire logic supply_low,
	// Two-wire bus
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Open-drain outputs
	output logic int_n_out,
	output logic int_n_oe,
	output logic square_wave_output,
	output logic square_wave_oe
);
	localparam int WD_W = $clog2(OSC_STOP_CYC + 1);

	rtc_bus_if bus();

	logic [2:0] osc_q;
	logic [1:0] sup_q;
	logic [WD_W-1:0] wd_q;
	logic dead_q;
	logic [rtc_pkg::DIV_W-1:0] div_q;
	logic [3:0] ptr_q;
	logic [7:0] cs1_q, cs2_q, cs2_d, sqw_q, tctl_q, cnt_q, load_q, rd_q;
	logic [7:0] tm_q [0:6];
	logic [7:0] al_q [0:3];
	logic vl_q, pend_q, match_q, pulse_q, int_q, sqw_oe_q;

	rtc_i2c_slave u_slave (
		.clk_sys(clk_sys),
		.rst(rst),
		.scl(scl),
		.sda_in(sda_in),
		.sda_oe(sda_oe),
		.bus(bus)
	);

	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		if (v >= hi)
			return {1'b1, lo};
		else if (v[3:0] == 4'h9)
			return {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
		else
			return {1'b0, v[7:4], 4'(v[3:0] + 4'h1)};
	endfunction : bcd_inc

	function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		unique case (m)
			8'h02: return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction : month_len

	// Pin synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			osc_q <= 3'h0;
			sup_q <= 2'h0;
		end else begin
			osc_q <= {osc_q[1:0], osc_clk};
			sup_q <= {sup_q[0], supply_low};
		end
	end
	wire osc_tick = osc_q[1] & ~osc_q[2];

	// Oscillator watchdog: reset held until edges are seen
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wd_q <= '0;
			dead_q <= 1'b1;
		end else if (osc_tick) begin
			wd_q <= '0;
			dead_q <= 1'b0;
		end else if (wd_q == WD_W'(OSC_STOP_CYC - 1)) begin
			dead_q <= 1'b1;
		end else begin
			wd_q <= wd_q + WD_W'(1);
		end
	end
	// Flop-driven, so the internal reset is glitch free
	wire rst_any = rst | dead_q;
	assign bus.bus_rst = dead_q;

	always_ff @(posedge clk_sys or posedge rst_any) begin
		if (rst_any)
			div_q <= '0;
		else if (osc_tick)
			div_q <= div_q + rtc_pkg::DIV_W'(1);
	end
	wire tick_4k = osc_tick & (&div_q[2:0]);
	wire tick_64 = osc_tick & (&div_q[8:0]);
	wire sec_ev = osc_tick & (&div_q) & ~cs1_q[rtc_pkg::B_STOP];
	wire min_ev = sec_ev & (tm_q[0][6:0] == 7'h59);

	// Register access decode
	wire w_any = bus.wr_stb;
	wire [7:0] wd = bus.wr_data & rtc_pkg::reg_mask(ptr_q);
	wire is_tm = ptr_q >= rtc_pkg::A_SEC && ptr_q <= rtc_pkg::A_YEAR;
	wire is_al = ptr_q >= rtc_pkg::A_AMIN && ptr_q <= rtc_pkg::A_AWDAY;
	wire [2:0] tm_idx = 3'(ptr_q - rtc_pkg::A_SEC);
	wire [1:0] al_idx = 2'(ptr_q - rtc_pkg::A_AMIN);
	wire w_cs1 = w_any && ptr_q == rtc_pkg::A_CS1;
	wire w_cs2 = w_any && ptr_q == rtc_pkg::A_CS2;
	wire w_sec = w_any && ptr_q == rtc_pkg::A_SEC;
	wire w_sqw = w_any && ptr_q == rtc_pkg::A_SQW;
	wire w_tctl = w_any && ptr_q == rtc_pkg::A_TCTL;
	wire w_tmr = w_any && ptr_q == rtc_pkg::A_TMR;

	always_ff @(posedge clk_sys or posedge rst_any) begin
		if (rst_any)
			ptr_q <= 4'h0;
		else if (bus.addr_stb)
			ptr_q <= bus.wr_data[3:0];
		else if (bus.wr_stb || bus.rd_done)
			ptr_q <= ptr_q + 4'h1;
	end

	// BCD calendar cascade
	wire [8:0] n_sec = bcd_inc({1'b0, tm_q[0][6:0]}, 8'h00, 8'h59);
	wire [8:0] n_min = bcd_inc(tm_q[1], 8'h00, 8'h59);
	wire [8:0] n_hr = bcd_inc(tm_q[2], 8'h00, 8'h23);
	wire [8:0] n_day = bcd_inc(tm_q[3], 8'h01, month_len({3'h0, tm_q[5][4:0]}, tm_q[6]));
	wire [8:0] n_wd = bcd_inc(tm_q[4], 8'h00, 8'h06);
	wire [8:0] n_mon = bcd_inc({3'h0, tm_q[5][4:0]}, 8'h01, 8'h12);
	wire [8:0] n_yr = bcd_inc(tm_q[6], 8'h00, 8'h99);
	// A second that lands during a read is kept and applied once it ends
	wire adv = ~bus.reading & (sec_ev | pend_q);

	always_ff @(posedge clk_sys or posedge rst_any) begin
		if (rst_any)
			pend_q <= 1'b0;
		else
			pend_q <= bus.reading & (pend_q | sec_ev);
	end

	always_ff @(posedge clk_sys or posedge rst_any) begin
		if (rst_any) begin
			for (int i = 0; i < 7; i++)
				tm_q[i] <= 8'h00;
		end else if (w_any && is_tm) begin
			tm_q[tm_idx] <= wd;
		end else if (adv) begin
			tm_q[0] <= n_sec[7:0];
			if (n_sec[8]) begin
				tm_q[1] <= n_min[7:0];
				if (n_min[8]) begin
					tm_q[2] <= n_hr[7:0];
					if (n_hr[8]) begin
						tm_q[3] <= n_day[7:0];
						tm_q[4] <= n_wd[7:0];
						if (n_day[8]) begin
							tm_q[5][4:0] <= n_mon[4:0];
							if (n_mon[8]) begin
								tm_q[6] <= n_yr[7:0];
								tm_q[5][7] <= tm_q[5][7] ^ n_yr[8];
							end
						end
					end
				end
			end
		end
	end

	// Control, alarm and square wave registers
	always_ff @(posedge clk_sys or posedge rst_any) begin
		if (rst_any) begin
			cs1_q <= rtc_pkg::CS1_RST;
			sqw_q <= rtc_pkg::SQW_RST;
			tctl_q <= rtc_pkg::TCTL_RST;
			for (int i = 0; i < 4; i++)
				al_q[i] <= rtc_pkg::ALM_RST;
		end else begin
			if (w_cs1)
				cs1_q <= wd;
			if (w_sqw)
				sqw_q <= wd;
			if (w_tctl)
				tctl_q <= wd;
			if (w_any && is_al)
				al_q[al_idx] <= wd;
		end
	end

	// Alarm: a disabled field always matches, all disabled never fires
	wire all_off = al_q[0][7] & al_q[1][7] & al_q[2][7] & al_q[3][7];
	wire match = ~all_off
		& (al_q[0][7] | al_q[0][6:0] == tm_q[1][6:0])
		& (al_q[1][7] | al_q[1][6:0] == tm_q[2][6:0])
		& (al_q[2][7] | al_q[2][6:0] == tm_q[3][6:0])
		& (al_q[3][7] | al_q[3][6:0] == tm_q[4][6:0]);
	wire al_set = match & ~match_q;

	// Countdown timer
	wire [1:0] td = tctl_q[1:0];
	wire src_tick = (td == 2'h0) ? tick_4k : (td == 2'h1) ? tick_64
		: (td == 2'h2) ? sec_ev : min_ev;
	wire tmr_go = tctl_q[rtc_pkg::B_TOP] & src_tick & (load_q != 8'h00) & ~w_tmr;
	wire tmr_end = tmr_go & (cnt_q <= 8'h01);

	always_ff @(posedge clk_sys or posedge rst_any) begin
		if (rst_any) begin
			cnt_q <= 8'h00;
			load_q <= 8'h00;
			pulse_q <= 1'b0;
			match_q <= 1'b0;
		end else begin
			match_q <= match;
			if (w_tmr) begin
				load_q <= bus.wr_data;
				cnt_q <= bus.wr_data;
			end else if (tmr_go) begin
				cnt_q <= tmr_end ? load_q : 8'(cnt_q - 8'h01);
			end
			// Pulse lasts until the next 4096 Hz tick
			if (tmr_end)
				pulse_q <= 1'b1;
			else if (tick_4k)
				pulse_q <= 1'b0;
		end
	end

	// Sticky flags: hardware set wins over a software clear
	wire af_d = al_set | (cs2_q[rtc_pkg::B_AF] & (~w_cs2 | bus.wr_data[rtc_pkg::B_AF]));
	wire tf_d = tmr_end | (cs2_q[rtc_pkg::B_TF] & (~w_cs2 | bus.wr_data[rtc_pkg::B_TF]));
	always_comb begin
		cs2_d = w_cs2 ? wd : cs2_q;
		cs2_d[rtc_pkg::B_AF] = af_d;
		cs2_d[rtc_pkg::B_TF] = tf_d;
	end

	always_ff @(posedge clk_sys or posedge rst_any) begin
		if (rst_any) begin
			cs2_q <= 8'h00;
			vl_q <= 1'b1;
		end else begin
			cs2_q <= cs2_d;
			vl_q <= sup_q[1] | (vl_q & ~(w_sec & ~bus.wr_data[7]));
		end
	end

	// Interrupt and square wave pins
	wire tmr_irq = cs2_q[rtc_pkg::B_TITP] ? pulse_q : cs2_q[rtc_pkg::B_TF];
	wire int_act = (cs2_q[rtc_pkg::B_AIE] & cs2_q[rtc_pkg::B_AF])
		| (cs2_q[rtc_pkg::B_TIE] & tmr_irq);
	wire [1:0] fd = sqw_q[1:0];
	wire wave = (fd == 2'h0) ? osc_q[2] : (fd == 2'h1) ? div_q[4]
		: (fd == 2'h2) ? div_q[9] : div_q[14];

	always_ff @(posedge clk_sys or posedge rst_any) begin
		if (rst_any) begin
			int_q <= 1'b0;
			sqw_oe_q <= 1'b0;
		end else begin
			int_q <= int_act;
			sqw_oe_q <= sqw_q[rtc_pkg::B_TOP] & ~wave;
		end
	end
	assign int_n_out = 1'b0;
	assign int_n_oe = int_q;
	assign square_wave_output = 1'b0;
	assign square_wave_oe = sqw_oe_q;
	assign sda_out = 1'b0;

	// Read data: timer gives the live count, seconds carry the supply flag
	wire [7:0] tm_rd = (ptr_q == rtc_pkg::A_SEC) ? {vl_q, tm_q[0][6:0]} : tm_q[tm_idx];
	wire [7:0] rd_val = is_tm ? tm_rd : is_al ? al_q[al_idx]
		: (ptr_q == rtc_pkg::A_CS1) ? cs1_q : (ptr_q == rtc_pkg::A_CS2) ? cs2_q
		: (ptr_q == rtc_pkg::A_SQW) ? sqw_q : (ptr_q == rtc_pkg::A_TCTL) ? tctl_q
		: cnt_q;
	always_ff @(posedge clk_sys or posedge rst_any) begin
		if (rst_any)
			rd_q <= 8'h00;
		else
			rd_q <= rd_val;
	end
	assign bus.rd_data = rd_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst_any);

	a_ptr_step: assert property ((bus.wr_stb || bus.rd_done) |=>
		ptr_q == 4'($past(ptr_q) + 4'h1)) else $error("pointer did not advance");
	a_ptr_wrap: assert property ((bus.rd_done && ptr_q == 4'hf) |=> ptr_q == 4'h0)
		else $error("pointer did not wrap");
	a_freeze_time: assert property (bus.reading |=> $stable(tm_q[0]) && $stable(tm_q[1]))
		else $error("time moved during read");
	a_alarm_sticky: assert property (cs2_q[rtc_pkg::B_AF] && !w_cs2 |=>
		cs2_q[rtc_pkg::B_AF]) else $error("alarm flag dropped");
	a_alarm_fire: assert property ($rose(match) |=> cs2_q[rtc_pkg::B_AF])
		else $error("alarm match missed");
	a_tmr_reload: assert property (tmr_end |=> cs2_q[rtc_pkg::B_TF]
		&& cnt_q == $past(load_q)) else $error("countdown end wrong");
	a_flag_clear: assert property (w_cs2 && !bus.wr_data[rtc_pkg::B_AF] && !al_set
		|=> !cs2_q[rtc_pkg::B_AF]) else $error("alarm flag not cleared");
	a_vl_set: assert property (sup_q[1] |=> vl_q) else $error("supply flag missed");
	a_vl_clear: assert property (w_sec && !bus.wr_data[7] && !sup_q[1] |=> !vl_q)
		else $error("supply flag not cleared");
	a_int_gate: assert property (int_n_oe |-> $past(cs2_q[rtc_pkg::B_AIE]
		|| cs2_q[rtc_pkg::B_TIE])) else $error("interrupt without enable");
	a_sqw_off: assert property (!sqw_q[rtc_pkg::B_TOP] |=> !square_wave_oe)
		else $error("square wave drives while off");
	a_reset_vals: assert property (@(posedge clk_sys) disable iff (rst)
		dead_q |=> (tctl_q == rtc_pkg::TCTL_RST && sqw_q == rtc_pkg::SQW_RST
			&& ptr_q == 4'h0 && vl_q)) else $error("reset values wrong");
	c_alarm: cover property ($rose(cs2_q[rtc_pkg::B_AF]));
	c_timer: cover property (tmr_end);
	c_irq: cover property ($rose(int_n_oe));
endmodule : rtc_top

/* File: tb/i2c_master_model.sv */
`timescale 1ns/1ps
module i2c_master_model (
	// Clock
	input wire logic clk_sys,
	// Bus wires
	input wire logic sda_in,
	output logic scl,
	output logic sda_drv
);
	// Quarter bit of 125 cycles: 400 kbit/s, never faster
	localparam int QTR = 125;

	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic q();
		repeat (QTR) @(negedge clk_sys);
	endtask : q

	// Data changes only while the clock is low, sampled mid high phase
	task automatic bit_io(input logic b, output logic s);
		sda_drv = b;
		q();
		scl = 1'b1;
		q();
		s = sda_in;
		q();
		scl = 1'b0;
		q();
	endtask : bit_io

	// Also serves as a repeated start
	task automatic start();
		sda_drv = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_drv = 1'b0;
		q();
		scl = 1'b0;
		q();
	endtask : start

	task automatic stop();
		sda_drv = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_drv = 1'b1;
		q();
	endtask : stop

	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, ack);
	endtask : put_byte

	task automatic get_byte(output logic [7:0] d, input logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(nack, s);
	endtask : get_byte
endmodule : i2c_master_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
`define CHK(name, exp, got) begin checks++; if ((got) !== (exp)) begin fails++; \
	$display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end
module tb;
	logic clk_sys;
	logic rst;
	logic osc_clk;
	logic supply_low;
	wire scl;
	wire sda_drv;
	wire sda_wire;
	logic sda_out;
	logic sda_oe;
	logic int_n_out;
	logic int_n_oe;
	logic square_wave_output;
	logic square_wave_oe;
	logic ack;
	logic sqw_seen;
	logic [7:0] rd;
	logic [7:0] boot [5] = '{8'h80, 8'h03, 8'h00, 8'h08, 8'h00};
	logic [7:0] last [3] = '{8'h00, 8'h0d, 8'h80};
	logic osc_run = 1'b1;
	int fails = 0;
	int checks = 0;

	// Pull-up on the data line
	assign sda_wire = sda_drv & ~sda_oe;

	rtc_top #(.OSC_STOP_CYC(200)) uut (
		.clk_sys(clk_sys),
		.rst(rst),
		.osc_clk(osc_clk),
		.supply_low(supply_low),
		.scl(scl),
		.sda_in(sda_wire),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.int_n_out(int_n_out),
		.int_n_oe(int_n_oe),
		.square_wave_output(square_wave_output),
		.square_wave_oe(square_wave_oe)
	);

	i2c_master_model m (
		.clk_sys(clk_sys),
		.sda_in(sda_wire),
		.scl(scl),
		.sda_drv(sda_drv)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Oscillator free-runs with no phase tie to the system clock
	initial begin
		osc_clk = 1'b0;
		#7.3;
		forever #32 osc_clk = ~osc_clk & osc_run;
	end

	task automatic summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	task automatic wait_sig(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK("wait", v, s)
		if (s !== v)
			summarize();
	endtask : wait_sig

	task automatic send(input logic [7:0] b);
		m.put_byte(b, ack);
		`CHK("ack", 1'b0, ack)
	endtask : send

	initial begin
		#600us;
		fails++;
		summarize();
	end

	initial begin
		rst = 1'b1;
		supply_low = 1'b0;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		repeat (40) @(negedge clk_sys);
		wait_sig(square_wave_oe, 1'b1, 100);
		wait_sig(square_wave_oe, 1'b0, 100);
		// Foreign address must be left alone
		m.start();
		m.put_byte(8'h90, ack);
		m.stop();
		`CHK("foreign nack", 1'b1, ack)
		// Read through the top of the map and back to zero
		m.start();
		send(8'ha2);
		send(8'h0d);
		m.start();
		send(8'ha3);
		for (int i = 0; i < 5; i++) begin
			m.get_byte(rd, i == 4);
			`CHK("reset value", boot[i], rd)
		end
		m.stop();
		// Arm weekday alarm, square wave off, timer 4096 Hz from 2, TIE, clear supply flag
		m.start();
		send(8'ha2);
		send(8'h0c);
		send(8'h00);
		send(8'h00);
		send(8'h80);
		send(8'h02);
		send(8'h00);
		send(8'h0d);
		send(8'h00);
		m.stop();
		sqw_seen = 1'b0;
		repeat (300) begin
			@(negedge clk_sys);
			sqw_seen = sqw_seen | square_wave_oe;
		end
		`CHK("square wave off", 1'b0, sqw_seen)
		// Supply dip after the clear sets the flag again
		supply_low = 1'b1;
		repeat (4) @(negedge clk_sys);
		supply_low = 1'b0;
		wait_sig(int_n_oe, 1'b1, 2000);
		// Pointer wrapped past 0Fh during the write; reread from zero
		m.start();
		send(8'ha2);
		send(8'h00);
		m.start();
		send(8'ha3);
		for (int i = 0; i < 3; i++) begin
			m.get_byte(rd, i == 2);
			`CHK("flags", last[i], rd)
		end
		m.stop();
		// Stopped oscillator must reset the registers, then restart cleanly
		osc_run = 1'b0;
		wait_sig(int_n_oe, 1'b0, 400);
		osc_run = 1'b1;
		wait_sig(square_wave_oe, 1'b1, 100);
		summarize();
	end
endmodule : tb
